// >>> core/rsc_pkg.sv
// constants and helpers shared by the rail state control register bank
package rsc_pkg;
   localparam logic [7:0] RSC_MAIN_RAIL_OFS = 8'h3A;
   localparam logic [7:0] RSC_GPS_SWITCH_OFS = 8'h4E;
   localparam logic [7:0] RSC_GENERAL_SWITCH_OFS = 8'h50;
   localparam logic [7:0] RSC_MAIN_RAIL_RST = 8'h24;
   localparam logic [7:0] RSC_GPS_SWITCH_RST = 8'h24;
   localparam logic [7:0] RSC_GENERAL_SWITCH_RST = 8'h24;
   localparam int RSC_STATE_LSB = 0;
   localparam int RSC_STATE_MSB = 2;
   localparam int RSC_EXIT_LSB = 3;
   localparam int RSC_EXIT_MSB = 5;
   localparam int RSC_FIELD_W = 3;
   localparam int RSC_HELD_W = 6;
   localparam logic [2:0] RSC_CODE_OFF = 3'h4;
   localparam logic [2:0] RSC_CODE_LOW_POWER = 3'h5;
   localparam logic [2:0] RSC_CODE_ACTIVE = 3'h6;

   typedef enum {RSC_MODE_RESERVED, RSC_MODE_OFF, RSC_MODE_LOW_POWER, RSC_MODE_ACTIVE} rsc_mode_t;

   // codes 4..7 are real states; 0..3 mean "leave as is" in the exit field
   function automatic logic rsc_code_valid(input logic [2:0] code);
      return code[2];
   endfunction

   function automatic rsc_mode_t rsc_decode(input logic [2:0] code);
      rsc_mode_t m;
      m = RSC_MODE_RESERVED;
      case (code)
         RSC_CODE_OFF: m = RSC_MODE_OFF;
         RSC_CODE_LOW_POWER: m = RSC_MODE_LOW_POWER;
         3'h6, 3'h7: m = RSC_MODE_ACTIVE;
         default: m = RSC_MODE_RESERVED;
      endcase
      return m;
   endfunction
endpackage

// >>> core/rsc_rail_cell.sv
// one rail control register: present state and standby-exit state
`timescale 1ns/1ps
module rsc_rail_cell #(
   parameter logic [7:0] RESET_VALUE = rsc_pkg::RSC_MAIN_RAIL_RST
) (
   input wire logic clock_i, // 20 MHz clock
   input wire logic nrst_i, // synchronous reset, active low
   input wire logic ce_i, // clock enable
   input wire logic wr_i, // write strobe for this register
   input wire logic [7:0] wdata_i, // write data
   input wire logic exit_i, // one-cycle standby exit event
   output logic [5:0] value_o // held fields, bits 5:0
);
   import rsc_pkg::*;

   logic [5:0] value;
   logic [5:0] next_value;

   always_comb begin
      next_value = value;
      if (wr_i) begin
         next_value = wdata_i[RSC_EXIT_MSB:RSC_STATE_LSB]; // bits 7:6 dropped
      end
      // exit copy uses the exit field held before any same-cycle write
      if (exit_i && rsc_code_valid(value[RSC_EXIT_MSB:RSC_EXIT_LSB])) begin
         next_value[RSC_STATE_MSB:RSC_STATE_LSB] = value[RSC_EXIT_MSB:RSC_EXIT_LSB];
      end
   end

   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         value <= RESET_VALUE[RSC_EXIT_MSB:RSC_STATE_LSB];
      end else if (ce_i) begin
         value <= next_value;
      end
   end

   assign value_o = value;
endmodule

// >>> core/rsc_state_regs.sv
// rail state control register bank with standby-exit copy
`timescale 1ns/1ps
module rsc_state_regs (
   input wire logic clock_i, // 20 MHz clock
   input wire logic nrst_i, // synchronous reset, active low
   input wire logic ce_i, // clock enable, freezes all state when low
   input wire logic [7:0] reg_addr_i, // register offset
   input wire logic reg_wr_i, // write strobe
   input wire logic [7:0] reg_wdata_i, // write data
   input wire logic reg_rd_i, // read strobe
   output logic [7:0] reg_rdata_o, // read data, held until next read
   output logic reg_rd_valid_o, // read data valid pulse
   input wire logic standby_exit_pin_i, // exit-standby pin, active high
   output logic [2:0] main_rail_state_o, // main rail present state
   output logic [2:0] gps_switch_state_o, // gps switch present state
   output logic [2:0] general_switch_state_o // general switch present state
);
   import rsc_pkg::*;

   logic exit_pin_q;
   logic next_exit_pin_q;
   logic exit_event;
   logic wr_main;
   logic wr_gps;
   logic wr_gen;
   logic [5:0] main_rail;
   logic [5:0] gps_switch;
   logic [5:0] general_switch;
   logic [7:0] rdata;
   logic [7:0] next_rdata;
   logic rd_valid;
   logic next_rd_valid;

   // edge, not level: a held pin must not keep undoing later writes
   assign exit_event = standby_exit_pin_i && !exit_pin_q;
   assign wr_main = reg_wr_i && (reg_addr_i == RSC_MAIN_RAIL_OFS);
   assign wr_gps = reg_wr_i && (reg_addr_i == RSC_GPS_SWITCH_OFS);
   assign wr_gen = reg_wr_i && (reg_addr_i == RSC_GENERAL_SWITCH_OFS);

   rsc_rail_cell #(.RESET_VALUE(RSC_MAIN_RAIL_RST)) u_main_rail (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .ce_i(ce_i),
      .wr_i(wr_main),
      .wdata_i(reg_wdata_i),
      .exit_i(exit_event),
      .value_o(main_rail)
   );

   rsc_rail_cell #(.RESET_VALUE(RSC_GPS_SWITCH_RST)) u_gps_switch (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .ce_i(ce_i),
      .wr_i(wr_gps),
      .wdata_i(reg_wdata_i),
      .exit_i(exit_event),
      .value_o(gps_switch)
   );

   rsc_rail_cell #(.RESET_VALUE(RSC_GENERAL_SWITCH_RST)) u_general_switch (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .ce_i(ce_i),
      .wr_i(wr_gen),
      .wdata_i(reg_wdata_i),
      .exit_i(exit_event),
      .value_o(general_switch)
   );

   always_comb begin
      next_exit_pin_q = standby_exit_pin_i;
      next_rd_valid = reg_rd_i;
      next_rdata = rdata;
      if (reg_rd_i) begin
         case (reg_addr_i)
            RSC_MAIN_RAIL_OFS: next_rdata = {2'h0, main_rail};
            RSC_GPS_SWITCH_OFS: next_rdata = {2'h0, gps_switch};
            RSC_GENERAL_SWITCH_OFS: next_rdata = {2'h0, general_switch};
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         exit_pin_q <= 1'b0;
         rdata <= 8'h00;
         rd_valid <= 1'b0;
      end else if (ce_i) begin
         exit_pin_q <= next_exit_pin_q;
         rdata <= next_rdata;
         rd_valid <= next_rd_valid;
      end
   end

   assign reg_rdata_o = rdata;
   assign reg_rd_valid_o = rd_valid;
   assign main_rail_state_o = main_rail[RSC_STATE_MSB:RSC_STATE_LSB];
   assign gps_switch_state_o = gps_switch[RSC_STATE_MSB:RSC_STATE_LSB];
   assign general_switch_state_o = general_switch[RSC_STATE_MSB:RSC_STATE_LSB];

   // main rail mode as seen by the regulator side, for checks
   rsc_mode_t main_mode;
   assign main_mode = rsc_decode(main_rail[RSC_STATE_MSB:RSC_STATE_LSB]);

   sequence s_exit_fire(logic [5:0] r, logic w);
      ce_i && exit_event && !w && rsc_code_valid(r[RSC_EXIT_MSB:RSC_EXIT_LSB]);
   endsequence

   sequence s_read_req(logic [7:0] a);
      ce_i && reg_rd_i && reg_addr_i == a;
   endsequence

   // writes that race an exit event go unchecked; the copy checks exclude writes too
   sequence s_write_only(logic w);
      ce_i && w && !exit_event;
   endsequence

   chk_gps_reset_value: assert property (
      @(posedge clock_i) disable iff (!nrst_i)
      $rose(nrst_i) |-> {2'h0, gps_switch} == RSC_GPS_SWITCH_RST)
      else $error("gps switch register reset value wrong");

   chk_main_reset_value: assert property (
      @(posedge clock_i) disable iff (!nrst_i)
      $rose(nrst_i) |-> {2'h0, main_rail} == RSC_MAIN_RAIL_RST)
      else $error("main rail register reset value wrong");

   chk_gps_write_store: assert property (
      @(posedge clock_i) disable iff (!nrst_i)
      ce_i && wr_gps && !exit_event |=> gps_switch == $past(reg_wdata_i[5:0]))
      else $error("gps switch write not stored");

   chk_main_exit_copy: assert property (
      @(posedge clock_i) disable iff (!nrst_i)
      s_exit_fire(main_rail, wr_main) |=>
         main_rail_state_o == $past(main_rail[5:3]) && main_mode != RSC_MODE_RESERVED)
      else $error("main rail exit state not copied");

   chk_general_exit_copy: assert property (
      @(posedge clock_i) disable iff (!nrst_i)
      s_exit_fire(general_switch, wr_gen) |=> general_switch_state_o == general_switch[5:3])
      else $error("general switch exit state not copied");

   chk_exit_no_copy: assert property (
      @(posedge clock_i) disable iff (!nrst_i)
      ce_i && exit_event && !wr_gps && !gps_switch[5] |=> $stable(gps_switch))
      else $error("gps switch changed on do-not-copy code");

   chk_exit_edge_once: assert property (
      @(posedge clock_i) disable iff (!nrst_i)
      ce_i && exit_event ##1 ce_i && standby_exit_pin_i && !wr_gps |=> $stable(gps_switch))
      else $error("held exit pin copied more than once");

   chk_read_gps_data: assert property (
      @(posedge clock_i) disable iff (!nrst_i)
      s_read_req(RSC_GPS_SWITCH_OFS) |=>
         reg_rd_valid_o && reg_rdata_o == {2'h0, $past(gps_switch)})
      else $error("gps switch read data wrong");

   chk_main_write_store: assert property (
      @(posedge clock_i) disable iff (!nrst_i)
      s_write_only(wr_main) |=> main_rail == $past(reg_wdata_i[5:0]))
      else $error("main rail write not stored");

   chk_general_write_store: assert property (
      @(posedge clock_i) disable iff (!nrst_i)
      s_write_only(wr_gen) |=> general_switch == $past(reg_wdata_i[5:0]))
      else $error("general switch write not stored");

   chk_general_reset_value: assert property (
      @(posedge clock_i) disable iff (!nrst_i)
      $rose(nrst_i) |-> {2'h0, general_switch} == RSC_GENERAL_SWITCH_RST)
      else $error("general switch register reset value wrong");

   chk_gps_exit_copy: assert property (
      @(posedge clock_i) disable iff (!nrst_i)
      s_exit_fire(gps_switch, wr_gps) |=> gps_switch_state_o == $past(gps_switch[5:3]))
      else $error("gps switch exit state not copied");

   chk_main_no_copy: assert property (
      @(posedge clock_i) disable iff (!nrst_i)
      ce_i && exit_event && !wr_main && !main_rail[5] |=> $stable(main_rail))
      else $error("main rail changed on do-not-copy code");

   chk_general_no_copy: assert property (
      @(posedge clock_i) disable iff (!nrst_i)
      ce_i && exit_event && !wr_gen && !general_switch[5] |=> $stable(general_switch))
      else $error("general switch changed on do-not-copy code");

   chk_read_main_data: assert property (
      @(posedge clock_i) disable iff (!nrst_i)
      s_read_req(RSC_MAIN_RAIL_OFS) |=>
         reg_rd_valid_o && reg_rdata_o == {2'h0, $past(main_rail)})
      else $error("main rail read data wrong");

   chk_read_general_data: assert property (
      @(posedge clock_i) disable iff (!nrst_i)
      s_read_req(RSC_GENERAL_SWITCH_OFS) |=>
         reg_rd_valid_o && reg_rdata_o == {2'h0, $past(general_switch)})
      else $error("general switch read data wrong");

   chk_read_valid_once: assert property (
      @(posedge clock_i) disable iff (!nrst_i)
      ce_i && !reg_rd_i |=> !reg_rd_valid_o)
      else $error("read valid without a read strobe");

   chk_read_reserved_zero: assert property (
      @(posedge clock_i) disable iff (!nrst_i)
      reg_rd_valid_o |-> reg_rdata_o[7:6] == 2'h0)
      else $error("reserved bits read nonzero");

   chk_ce_freeze: assert property (
      @(posedge clock_i) disable iff (!nrst_i)
      !ce_i |=> $stable(main_rail) && $stable(gps_switch) && $stable(general_switch)
         && $stable(reg_rd_valid_o))
      else $error("state moved with clock enable low");
endmodule

// >>> tb/rsc_ctrl_model.sv
// controller model driving the register strobe port and the exit pin
`timescale 1ns/1ps
module rsc_ctrl_model (
   input wire logic clock_i, // bench clock
   input wire logic [7:0] reg_rdata_i, // read data
   input wire logic reg_rd_valid_i, // read data valid
   output logic ce_o, // clock enable
   output logic [7:0] reg_addr_o, // register offset
   output logic reg_wr_o, // write strobe
   output logic [7:0] reg_wdata_o, // write data
   output logic reg_rd_o, // read strobe
   output logic standby_exit_pin_o // exit pin
);
   initial begin
      ce_o = 1'b1;
      reg_addr_o = 8'h00;
      reg_wr_o = 1'b0;
      reg_wdata_o = 8'h00;
      reg_rd_o = 1'b0;
      standby_exit_pin_o = 1'b0;
   end
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock_i);
      reg_addr_o = a;
      reg_wdata_o = d;
      reg_wr_o = 1'b1;
      @(negedge clock_i);
      reg_wr_o = 1'b0;
      // stale data must not look valid
      reg_wdata_o = ~d;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output bit ok);
      int i;
      @(negedge clock_i);
      reg_addr_o = a;
      reg_rd_o = 1'b1;
      @(negedge clock_i);
      reg_rd_o = 1'b0;
      ok = 1'b0;
      d = 8'hXX;
      for (i = 0; i < 4 && !ok; i++) begin
         if (reg_rd_valid_i === 1'b1) begin
            ok = 1'b1;
            d = reg_rdata_i;
         end else begin
            @(negedge clock_i);
         end
      end
   endtask
   task automatic exit_pulse();
      @(negedge clock_i);
      standby_exit_pin_o = 1'b1;
      @(negedge clock_i);
      standby_exit_pin_o = 1'b0;
      // low for one cycle so the next pulse is a new edge
      @(negedge clock_i);
   endtask
   task automatic set_ce(input logic v);
      @(negedge clock_i);
      ce_o = v;
   endtask
   // level control of the pin, for holds longer than one cycle
   task automatic set_pin(input logic v);
      @(negedge clock_i);
      standby_exit_pin_o = v;
   endtask
endmodule

// >>> tb/testbench.sv
// self-checking bench for the rail state control register bank
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_fail++; \
   $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module testbench;
   import rsc_pkg::*;
   logic clock_i = 1'b0;
   logic nrst_i = 1'b0;
   logic ce, wr, rdstb, pin, valid;
   logic [7:0] addr, wdata, rdata, rd;
   logic [2:0] main_st, gps_st, gen_st;
   logic [3:0] c;
   int n_fail = 0;
   int tests_run = 0;
   always #25 clock_i = ~clock_i;
   rsc_state_regs rsc_state_regs_inst (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce),
      .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rdstb),
      .reg_rdata_o(rdata), .reg_rd_valid_o(valid), .standby_exit_pin_i(pin),
      .main_rail_state_o(main_st), .gps_switch_state_o(gps_st),
      .general_switch_state_o(gen_st));
   rsc_ctrl_model rsc_ctrl_model_inst (.clock_i(clock_i), .reg_rdata_i(rdata),
      .reg_rd_valid_i(valid), .ce_o(ce), .reg_addr_o(addr), .reg_wr_o(wr),
      .reg_wdata_o(wdata), .reg_rd_o(rdstb), .standby_exit_pin_o(pin));
   task automatic test_done();
      $display("compares %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      bit ok;
      rsc_ctrl_model_inst.rd_reg(a, rd, ok);
      if (!ok) begin
         n_fail++;
         test_done();
      end else begin
         `CHK(rd, e)
      end
   endtask
   initial begin
      repeat (4) @(negedge clock_i);
      nrst_i = 1'b1;
      rd_chk(RSC_MAIN_RAIL_OFS, 8'h24);
      rd_chk(RSC_GPS_SWITCH_OFS, 8'h24);
      rd_chk(RSC_GENERAL_SWITCH_OFS, 8'h24);
      `CHK(main_st, RSC_CODE_OFF)
      rsc_ctrl_model_inst.wr_reg(RSC_MAIN_RAIL_OFS, 8'hFF);
      rd_chk(RSC_MAIN_RAIL_OFS, 8'h3F);
      `CHK(main_st, 3'h7)
      rsc_ctrl_model_inst.wr_reg(RSC_GPS_SWITCH_OFS, 8'h3E);
      `CHK(gps_st, RSC_CODE_ACTIVE)
      rd_chk(8'h3B, 8'h00);
      for (c = 4'h0; c < 4'h8; c++) begin
         // exit fields written before each exit event
         rsc_ctrl_model_inst.wr_reg(RSC_MAIN_RAIL_OFS, {2'h0, c[2:0], 3'h5});
         rsc_ctrl_model_inst.wr_reg(RSC_GPS_SWITCH_OFS, {2'h3, c[2:0], 3'h5});
         rsc_ctrl_model_inst.wr_reg(RSC_GENERAL_SWITCH_OFS, {2'h0, c[2:0], 3'h4});
         rsc_ctrl_model_inst.exit_pulse();
         `CHK(main_st, c[2] ? c[2:0] : 3'h5)
         `CHK(gps_st, c[2] ? c[2:0] : 3'h5)
         `CHK(gen_st, c[2] ? c[2:0] : 3'h4)
         rd_chk(RSC_GPS_SWITCH_OFS, {2'h0, c[2:0], c[2] ? c[2:0] : 3'h5});
      end
      // pin held high: one copy only, later writes stay
      rsc_ctrl_model_inst.wr_reg(RSC_GPS_SWITCH_OFS, 8'h25);
      rsc_ctrl_model_inst.set_pin(1'b1);
      repeat (2) @(negedge clock_i);
      `CHK(gps_st, RSC_CODE_OFF)
      rsc_ctrl_model_inst.wr_reg(RSC_GPS_SWITCH_OFS, 8'h35);
      rsc_ctrl_model_inst.set_pin(1'b0);
      `CHK(gps_st, RSC_CODE_LOW_POWER)
      rsc_ctrl_model_inst.exit_pulse();
      `CHK(gps_st, RSC_CODE_ACTIVE)
      // write and exit on one edge: state takes the old exit field
      fork
         rsc_ctrl_model_inst.wr_reg(RSC_MAIN_RAIL_OFS, 8'h26);
         rsc_ctrl_model_inst.exit_pulse();
      join
      `CHK(main_st, 3'h7)
      rd_chk(RSC_MAIN_RAIL_OFS, 8'h27);
      // clock enable low: strobes and pin edges are ignored
      rsc_ctrl_model_inst.set_ce(1'b0);
      rsc_ctrl_model_inst.wr_reg(RSC_GPS_SWITCH_OFS, 8'h2C);
      rsc_ctrl_model_inst.exit_pulse();
      rsc_ctrl_model_inst.set_ce(1'b1);
      `CHK(main_st, 3'h7)
      `CHK(gps_st, RSC_CODE_ACTIVE)
      rd_chk(RSC_GPS_SWITCH_OFS, 8'h36);
      // second reset in mid-run
      @(negedge clock_i);
      nrst_i = 1'b0;
      repeat (2) @(negedge clock_i);
      nrst_i = 1'b1;
      `CHK(main_st, RSC_CODE_OFF)
      `CHK(gps_st, RSC_CODE_OFF)
      `CHK(gen_st, RSC_CODE_OFF)
      rd_chk(RSC_GENERAL_SWITCH_OFS, RSC_GENERAL_SWITCH_RST);
      rd_chk(RSC_MAIN_RAIL_OFS, RSC_MAIN_RAIL_RST);
      test_done();
   end
endmodule
